/* File: include/ibp_pkg.sv */
// constants and types for the isa bus and board pin control block
// assumes a single 250 MHz clock domain and plain-port configuration bits
// Functional notes
// RULE_01: after an honoured dma acknowledge, assert master to claim the bus
// RULE_02: as current master, drive memory read or write strobe low per cycle
// RULE_03: ignore dma acknowledge while refresh is active
// RULE_04: while reset is held, reset everything and park outputs inactive; the eeprom pin and flag registers clear on RST_N and sleep only, not on RESET
// RULE_05: host holds reset for at least ten crystal periods
// RULE_06: device resets itself at power up without the reset pin
// RULE_07: drive system address as master, else decode it for slave matches
// RULE_08: driven system address bits 17-19 equal the unlatched bits 17-19
// RULE_09: drive byte high enable during own master transfers
// RULE_10: drive data on master writes and slave reads, capture otherwise
// RULE_11: address prom select on i/o reads of first 16 bytes, pass prom byte
// RULE_12: by default the shared pin acts as interrupt request fifteen
// RULE_13: boot prom select on block match with memory read and no refresh
// RULE_14: transceiver disable level follows polarity bit, inverted when set
// RULE_15: in external detect mode pin is reject input, or-ed with filter result
// RULE_16: leds active low; detect mode puts frame, data, clock on leds 1-3
// RULE_17: eeprom port bit set makes private bus bits 2,1,0 the eeprom pins
// RULE_18: shift busy only while shifting eeprom data after reset or reload
// RULE_19: shift busy input low flags an eeprom checksum error
// RULE_20: eeprom chip select under control register and during auto read
// RULE_21: sleep resets internally, parks outputs, ignores other inputs
// RULE_22: host waits half a second after sleep release before starting
// RULE_23: as master, stretch the bus cycle while channel ready is low
package ibp_pkg;
	localparam int          CLK_MHZ          = 250;
	localparam int          RESET_MIN_XTAL   = 10;     // crystal periods
	localparam int          XTAL_MHZ         = 20;
	localparam int          RESET_MIN_CYC    = (RESET_MIN_XTAL * CLK_MHZ + XTAL_MHZ - 1) / XTAL_MHZ;
	localparam int          CYC_PHASE        = 2;      // clocks per strobe phase
	localparam int          EE_BITS          = 16;     // bits shifted per auto read
	localparam int          EE_HALF_CYC      = 8;      // clocks per serial clock half period
	localparam int          CTL_EE_PORT_BIT  = 4;      // eeprom port enable in control word
	localparam int          CTL_RELOAD_BIT   = 14;     // eeprom reload request
	localparam int          PNP_XPOL_BIT     = 5;      // polarity bit in config 0xF0
	localparam logic [7:0]  PNP_CFG_REG      = 8'hF0;
	localparam logic [9:0]  IO_WIN_MASK      = 10'h3F0; // first 16 i/o bytes
	localparam logic [2:0]  POR_CYC          = 3'h7;    // power-up self reset length
	typedef enum logic [2:0] {IBP_IDLE, IBP_ADDR, IBP_STRB, IBP_WAIT, IBP_DONE} ibp_bus_t;
endpackage : ibp_pkg

/* File: rtl/ibp_ee_shift.sv */
// eeprom serial read sequencer used after reset and on reload requests
// assumes inputs already synchronised by the top module
`timescale 1ns/10ps
`default_nettype none
module ibp_ee_shift
	import ibp_pkg::*;
(
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// control
	input  wire logic        start,
	input  wire logic        data_in,
	// status
	output logic             busy,
	output logic             sclk,
	output logic             csel,
	output logic [EE_BITS-1:0] word
);
	logic [4:0] bit_cnt;
	logic [3:0] half_cnt;

	// bit clock generator and shifter; a start while busy is absorbed
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			busy     <= 1'b0;
			sclk     <= 1'b0;
			csel     <= 1'b0;
			bit_cnt  <= 5'h00;
			half_cnt <= 4'h0;
			word     <= '0;
		end else if (!busy) begin
			sclk <= 1'b0;
			if (start) begin
				busy    <= 1'b1;    // RULE_18
				csel    <= 1'b1;    // RULE_20
				bit_cnt <= 5'h00;
			end
		end else if (half_cnt == 4'(EE_HALF_CYC - 1)) begin
			half_cnt <= 4'h0;
			sclk     <= ~sclk;
			if (!sclk) begin
				word <= {word[EE_BITS-2:0], data_in};
			end else if (bit_cnt == 5'(EE_BITS - 1)) begin
				busy <= 1'b0;       // RULE_18
				csel <= 1'b0;
			end else begin
				bit_cnt <= bit_cnt + 5'h01;
			end
		end else begin
			half_cnt <= half_cnt + 4'h1;
		end
	end

	busy_bound_a: assert property (@(posedge clk) disable iff (!rst_n)
		$rose(busy) |-> ##[1:600] !busy) else $error("shift never ends"); // RULE_18
	cs_busy_a: assert property (@(posedge clk) disable iff (!rst_n)
		busy |-> csel) else $error("chip select dropped while shifting"); // RULE_20
endmodule : ibp_ee_shift
`default_nettype wire

/* File: rtl/ibp_top.sv */
// isa bus master sequencing, slave decode and board pin control
// assumes pins are resolved by the bench from output enables; one clock
`timescale 1ns/10ps
`default_nettype none
module ibp_top
	import ibp_pkg::*;
(
	// clock and reset
	input  wire logic        CLOCK,
	input  wire logic        RST_N,
	input  wire logic        RESET,
	input  wire logic        SLEEP_N,
	// dma handshake
	input  wire logic        DMA_REQ,
	input  wire logic        DACK_N,
	input  wire logic        REF_N,
	output logic             MASTER_N,
	// master cycle request from the core
	input  wire logic        XFER_WRITE,
	input  wire logic [23:0] XFER_ADDR,
	input  wire logic        XFER_HIGH,
	input  wire logic [15:0] XFER_WDATA,
	output logic             XFER_DONE,
	output logic [15:0]      XFER_RDATA,
	input  wire logic        IOCHRDY,
	// memory strobes
	output logic             MEMR_N_O,
	output logic             MEMW_N_O,
	output logic             MEMS_OE,
	input  wire logic        MEMR_N_I,
	// address and byte enable
	input  wire logic [19:0] SA_I,
	output logic [19:0]      SA_O,
	output logic             SA_OE,
	output logic [23:17]     LA_O,
	output logic             SBHE_N_O,
	input  wire logic        AEN,
	input  wire logic        IOR_N,
	input  wire logic        IOW_N,
	// data bus
	input  wire logic [15:0] SD_I,
	output logic [15:0]      SD_O,
	output logic             SD_OE,
	output logic [15:0]      SLAVE_WDATA,
	input  wire logic [15:0] SLAVE_RDATA,
	// decode configuration
	input  wire logic [9:0]  IO_BASE,
	input  wire logic [19:14] PROM_BASE,
	input  wire logic        ADDR_PROM_SELECT_MODE,
	input  wire logic        IRQ_LEVEL,
	output logic             IRQ15_ADDR_PROM_SELECT_N,
	output logic             BOOT_PROM_SELECT_N,
	input  wire logic [7:0]  PRIVATE_PROM_BUS_I,
	output logic [2:0]       PRIVATE_PROM_BUS_O,
	output logic             PRIVATE_PROM_BUS_OE,
	// transceiver and leds
	input  wire logic        XCVR_DISABLE_POLARITY,
	input  wire logic        TP_ACTIVE,
	input  wire logic        EXT_ADDR_DETECT_MODE,
	input  wire logic        EXT_ADDR_REJECT_N,
	input  wire logic        FILTER_REJECT,
	output logic             XCVR_DISABLE_OUT,
	output logic             XCVR_DISABLE_OE,
	output logic             FRAME_REJECT,
	input  wire logic [3:0]  LED_STATUS,
	input  wire logic        START_FRAME_BYTE_DELIM,
	input  wire logic        SERIAL_RX_DATA,
	input  wire logic        SERIAL_RX_CLOCK,
	output logic [3:0]       LED_N,
	// eeprom control
	input  wire logic [15:0] EEPROM_CONTROL_REG,
	input  wire logic        EEPROM_RELOAD_BIT,
	input  wire logic        EEPROM_SHIFT_BUSY_I,
	output logic             EEPROM_SHIFT_BUSY_O,
	output logic             EEPROM_CHIP_SELECT,
	output logic             EEPROM_CHECKSUM_ERR,
	output logic [15:0]      EEPROM_WORD,
	output logic             SLEEPING
);
	logic [1:0]  s_sleep, s_dack, s_ref, s_rdy, s_aen, s_ior, s_iow, s_memr, s_ear, s_sbusy;
	logic [19:0] s1_sa, sa_q;
	logic [15:0] s1_sd, sd_q;
	logic [7:0]  s1_pb, pb_q;
	logic [2:0]  por_cnt = 3'h0;
	logic [1:0]  s_rst;
	logic        rst_i, reload_q, ee_start, ee_busy, ee_sclk, ee_cs;
	logic [15:0] ee_word;
	logic        req_win, is_master, io_hit, prom_hit;
	logic [1:0]  ph_cnt;
	ibp_bus_t    st, next_st;

	function automatic logic io_match(input logic [19:0] a, input logic [9:0] base);
		io_match = (a[9:0] & IO_WIN_MASK) == (base & IO_WIN_MASK);
	endfunction : io_match

	// two-stage synchronisers for every pin input except RST_N and DMA_REQ
	always_ff @(posedge CLOCK) begin
		s_sleep <= {s_sleep[0], SLEEP_N};
		s_rst   <= {s_rst[0], RESET};
		s_dack  <= {s_dack[0], DACK_N};
		s_ref   <= {s_ref[0], REF_N};
		s_rdy   <= {s_rdy[0], IOCHRDY};
		s_aen   <= {s_aen[0], AEN};
		s_ior   <= {s_ior[0], IOR_N};
		s_iow   <= {s_iow[0], IOW_N};
		s_memr  <= {s_memr[0], MEMR_N_I};
		s_ear   <= {s_ear[0], EXT_ADDR_REJECT_N};
		s_sbusy <= {s_sbusy[0], EEPROM_SHIFT_BUSY_I};
		s1_sa   <= SA_I;
		sa_q    <= s1_sa;
		s1_sd   <= SD_I;
		sd_q    <= s1_sd;
		s1_pb   <= PRIVATE_PROM_BUS_I;
		pb_q    <= s1_pb;
	end

	// power-up self reset; the counter's initial value stands in for power-on
	always_ff @(posedge CLOCK) begin
		if (por_cnt != POR_CYC)
			por_cnt <= por_cnt + 3'h1; // RULE_06
	end

	// internal reset merges pin reset, sleep and power-up; held inputs may bounce
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			rst_i <= 1'b1;
		end else begin
			rst_i <= s_rst[1] || !s_sleep[1] || por_cnt != POR_CYC; // RULE_04 RULE_21
		end
	end

	// acknowledge during refresh is treated as noise
	assign req_win   = DMA_REQ && !s_dack[1] && s_ref[1]; // RULE_03
	assign is_master = st != IBP_IDLE;

	// bus master cycle sequencer
	always_comb begin
		next_st = st;
		unique case (st)
			IBP_IDLE: if (req_win) next_st = IBP_ADDR; // RULE_01
			IBP_ADDR: if (ph_cnt == 2'(CYC_PHASE - 1)) next_st = IBP_STRB;
			IBP_STRB: if (ph_cnt == 2'(CYC_PHASE - 1)) next_st = IBP_WAIT;
			IBP_WAIT: if (s_rdy[1]) next_st = IBP_DONE; // RULE_23
			IBP_DONE: next_st = IBP_IDLE;
		endcase
	end

	always_ff @(posedge CLOCK) begin
		if (!RST_N || rst_i) begin
			st     <= IBP_IDLE;
			ph_cnt <= 2'h0;
		end else begin
			st     <= next_st;
			ph_cnt <= (next_st != st) ? 2'h0 : ph_cnt + 2'h1;
		end
	end

	// master-side pin drive; strobes span strobe and wait states
	always_ff @(posedge CLOCK) begin
		if (!RST_N || rst_i) begin
			MASTER_N   <= 1'b1;
			MEMR_N_O   <= 1'b1;
			MEMW_N_O   <= 1'b1;
			MEMS_OE    <= 1'b0;
			SA_O       <= 20'h00000;
			SA_OE      <= 1'b0;
			LA_O       <= 7'h00;
			SBHE_N_O   <= 1'b1;
			XFER_DONE  <= 1'b0;
			XFER_RDATA <= 16'h0000;
		end else begin
			MASTER_N  <= !(is_master || next_st != IBP_IDLE); // RULE_01
			MEMS_OE   <= next_st != IBP_IDLE;
			SA_OE     <= next_st != IBP_IDLE; // RULE_07
			SA_O      <= {XFER_ADDR[19:17], XFER_ADDR[16:0]};
			LA_O      <= XFER_ADDR[23:17]; // RULE_08
			SBHE_N_O  <= !(XFER_HIGH && next_st != IBP_IDLE); // RULE_09
			MEMR_N_O  <= !(!XFER_WRITE && (next_st == IBP_STRB || next_st == IBP_WAIT)); // RULE_02
			MEMW_N_O  <= !(XFER_WRITE && (next_st == IBP_STRB || next_st == IBP_WAIT)); // RULE_02
			XFER_DONE <= st == IBP_WAIT && next_st == IBP_DONE;
			if (st == IBP_WAIT && s_rdy[1] && !XFER_WRITE)
				XFER_RDATA <= sd_q; // RULE_10
		end
	end

	// slave decode runs only while another master owns the address lines
	assign io_hit   = !is_master && !s_aen[1] && io_match(sa_q, IO_BASE); // RULE_07
	assign prom_hit = !is_master && sa_q[19:14] == PROM_BASE && !s_memr[1] && s_ref[1]; // RULE_13

	// data bus, prom selects and slave capture
	always_ff @(posedge CLOCK) begin
		if (!RST_N || rst_i) begin
			SD_O               <= 16'h0000;
			SD_OE              <= 1'b0;
			SLAVE_WDATA        <= 16'h0000;
			IRQ15_ADDR_PROM_SELECT_N       <= 1'b1;
			BOOT_PROM_SELECT_N <= 1'b1;
		end else begin
			BOOT_PROM_SELECT_N <= !prom_hit; // RULE_13
			IRQ15_ADDR_PROM_SELECT_N <= ADDR_PROM_SELECT_MODE ? !(io_hit && !s_ior[1] && sa_q[3:0] <= 4'hF) // RULE_11
			                          : !IRQ_LEVEL; // RULE_12
			if (is_master) begin
				SD_OE <= XFER_WRITE && next_st != IBP_ADDR && next_st != IBP_IDLE; // RULE_10
				SD_O  <= XFER_WDATA;
			end else if (prom_hit || (ADDR_PROM_SELECT_MODE && io_hit && !s_ior[1])) begin
				SD_OE <= 1'b1;
				SD_O  <= {8'h00, pb_q}; // RULE_11 RULE_13
			end else begin
				SD_OE <= io_hit && !s_ior[1]; // RULE_10
				SD_O  <= SLAVE_RDATA;
			end
			if (io_hit && !s_iow[1])
				SLAVE_WDATA <= sd_q; // RULE_10
		end
	end

	// transceiver disable, reject merge and leds
	always_ff @(posedge CLOCK) begin
		if (!RST_N || rst_i) begin
			XCVR_DISABLE_OUT <= !XCVR_DISABLE_POLARITY; // sleep level: twisted pair state
			XCVR_DISABLE_OE  <= 1'b1;
			FRAME_REJECT     <= 1'b0;
			LED_N            <= 4'hF;
		end else begin
			XCVR_DISABLE_OE  <= !EXT_ADDR_DETECT_MODE; // RULE_15
			XCVR_DISABLE_OUT <= TP_ACTIVE ^ XCVR_DISABLE_POLARITY; // RULE_14
			FRAME_REJECT     <= FILTER_REJECT || (EXT_ADDR_DETECT_MODE && !s_ear[1]); // RULE_15
			LED_N[0] <= !LED_STATUS[0]; // RULE_16
			LED_N[1] <= EXT_ADDR_DETECT_MODE ? !START_FRAME_BYTE_DELIM : !LED_STATUS[1]; // RULE_16
			LED_N[2] <= EXT_ADDR_DETECT_MODE ? !SERIAL_RX_DATA : !LED_STATUS[2]; // RULE_16
			LED_N[3] <= EXT_ADDR_DETECT_MODE ? !SERIAL_RX_CLOCK : !LED_STATUS[3]; // RULE_16
		end
	end

	// reload edge and the automatic read at the end of an internal reset
	always_ff @(posedge CLOCK) begin
		if (!RST_N) begin
			reload_q <= 1'b0;
			ee_start <= 1'b0;
		end else begin
			reload_q <= EEPROM_RELOAD_BIT;
			ee_start <= (EEPROM_RELOAD_BIT && !reload_q) || (rst_i && !(s_rst[1] || !s_sleep[1])); // RULE_18
		end
	end

	ibp_ee_shift u_shift (
		.clk     (CLOCK),
		.rst_n   (RST_N && !(s_rst[1] || !s_sleep[1])),
		.start   (ee_start),
		.data_in (pb_q[2]),
		.busy    (ee_busy),
		.sclk    (ee_sclk),
		.csel    (ee_cs),
		.word    (ee_word)
	);

	// eeprom pin ownership and checksum flag
	always_ff @(posedge CLOCK) begin
		if (!RST_N || !s_sleep[1]) begin
			PRIVATE_PROM_BUS_O  <= 3'h0;
			PRIVATE_PROM_BUS_OE <= 1'b0;
			EEPROM_CHIP_SELECT  <= 1'b0;
			EEPROM_SHIFT_BUSY_O <= 1'b0;
			EEPROM_CHECKSUM_ERR <= 1'b0;
			EEPROM_WORD         <= 16'h0000;
			SLEEPING            <= !RST_N ? 1'b0 : 1'b1;
		end else begin
			SLEEPING <= 1'b0;
			PRIVATE_PROM_BUS_OE <= ee_busy || EEPROM_CONTROL_REG[CTL_EE_PORT_BIT]; // RULE_17
			PRIVATE_PROM_BUS_O  <= ee_busy ? {1'b0, 1'b0, ee_sclk}
			                               : {1'b0, EEPROM_CONTROL_REG[1:0]}; // RULE_17
			EEPROM_CHIP_SELECT  <= ee_cs || (EEPROM_CONTROL_REG[CTL_EE_PORT_BIT]
			                                 && EEPROM_CONTROL_REG[2]); // RULE_20
			EEPROM_SHIFT_BUSY_O <= ee_busy; // RULE_18
			if (ee_busy && !s_sbusy[1])
				EEPROM_CHECKSUM_ERR <= 1'b1; // RULE_19
			else if (ee_start)
				EEPROM_CHECKSUM_ERR <= 1'b0;
			if (!ee_busy)
				EEPROM_WORD <= ee_word;
		end
	end

	ref_mask_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		(st == IBP_IDLE && !s_ref[1]) |=> st == IBP_IDLE) else $error("dack taken in refresh"); // RULE_03
	master_on_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		(st == IBP_ADDR) |-> !MASTER_N) else $error("master not asserted"); // RULE_01
	ready_hold_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		(st == IBP_WAIT && !s_rdy[1]) |=> st == IBP_WAIT) else $error("cycle not stretched"); // RULE_23
	strobe_dir_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		!(MEMR_N_O == 1'b0 && MEMW_N_O == 1'b0)) else $error("both strobes low"); // RULE_02
	addr_own_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		SA_OE |-> SA_O[19:17] == LA_O[19:17]) else $error("upper address mismatch"); // RULE_08
	reset_park_a: assert property (@(posedge CLOCK) disable iff (!RST_N)
		$past(rst_i) |-> (MASTER_N && !SA_OE && !SD_OE && LED_N == 4'hF)) else $error("outputs live in reset"); // RULE_04
	xcvr_pol_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		$past(RST_N) && !$past(rst_i) &&
		$past(XCVR_DISABLE_POLARITY) == $past(XCVR_DISABLE_POLARITY, 2) && $past(TP_ACTIVE) == $past(TP_ACTIVE, 2)
		|-> XCVR_DISABLE_OUT == ($past(TP_ACTIVE) ^ $past(XCVR_DISABLE_POLARITY))) else $error("xcvr level wrong"); // RULE_14
	prom_sel_a: assert property (@(posedge CLOCK) disable iff (!RST_N || rst_i)
		!BOOT_PROM_SELECT_N |-> $past(s_ref[1])) else $error("prom select in refresh"); // RULE_13
endmodule : ibp_top
`default_nettype wire

/* File: tb/ibp_host_model.sv */
// permanent master and slow memory model facing the bus master pins
// assumes the bench resolves shared pins and feeds it the bus address
`timescale 1ns/10ps
`default_nettype none
module ibp_host_model (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst_n,
	// arbitration
	input  wire logic        dma_req,
	input  wire logic        master_n,
	output logic             dack_n,
	// memory cycle
	input  wire logic        memr_n,
	input  wire logic        memw_n,
	input  wire logic        mems_oe,
	input  wire logic [19:0] sa,
	input  wire logic [3:0]  wait_cyc,
	output logic             iochrdy,
	output logic [15:0]      rdata
);
	logic [1:0]  ack_cnt;
	logic [3:0]  wcnt;
	logic [15:0] last;
	logic        strobe;
	assign strobe = mems_oe & ~(memr_n & memw_n);
	// grant four cycles after the request, withdraw it as soon as it drops
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ack_cnt <= 2'h0;
			dack_n  <= 1'b1;
		end else begin
			ack_cnt <= dma_req ? ack_cnt + {1'b0, ack_cnt != 2'h3} : 2'h0;
			dack_n  <= ~(dma_req & ack_cnt == 2'h3);
		end
	end
	// ready is pulled low from master assertion until wait_cyc strobe cycles have passed
	always_ff @(posedge clk) begin
		if (!rst_n) wcnt <= 4'h0;
		else wcnt <= strobe ? wcnt + {3'h0, wcnt != 4'hF} : 4'h0;
	end
	assign iochrdy = ~(~master_n & wcnt < wait_cyc);
	// a released bus toggles so that stale data never passes for a read
	always_ff @(posedge clk) begin
		if (!rst_n) last <= 16'h0000;
		else last <= rdata;
	end
	assign rdata = (strobe & ~memr_n) ? sa[15:0] ^ 16'h5A3C : ~last;
endmodule : ibp_host_model
`default_nettype wire

/* File: tb/tb.sv */
// self-checking bench for the isa bus and board pin block
// assumes the host model and one 250 MHz clock; pins resolved here
`timescale 1ns/10ps
`default_nettype none
`define CHK(a,b) begin tests_run++; if ((a)!==(b)) begin err_count++; \
	$display("[ERR] %0t got %h want %h", $time, (a), (b)); end end
module tb
	import ibp_pkg::*;
;
	int err_count = 0, tests_run = 0, i;
	logic CLOCK, RST_N = 1'b0, RESET = 1'b0, SLEEP_N = 1'b1, DMA_REQ = 1'b0, REF_N = 1'b1;
	logic XFER_WRITE = 1'b0, XFER_HIGH = 1'b0, AEN = 1'b1, IOR_N = 1'b1, IOW_N = 1'b1;
	logic ADDR_PROM_SELECT_MODE = 1'b0, IRQ_LEVEL = 1'b0, XCVR_DISABLE_POLARITY = 1'b0, TP_ACTIVE = 1'b0;
	logic EXT_ADDR_DETECT_MODE = 1'b0, FILTER_REJECT = 1'b0, ext_addr_reject_n = 1'b1, bmemr_n = 1'b1;
	logic START_FRAME_BYTE_DELIM = 1'b0, SERIAL_RX_DATA = 1'b0, SERIAL_RX_CLOCK = 1'b0;
	logic EEPROM_RELOAD_BIT = 1'b0, EEPROM_SHIFT_BUSY_I = 1'b1, bsd_en = 1'b0;
	logic [23:0]  XFER_ADDR = 24'h000000;
	logic [19:0]  bsa = 20'h00000;
	logic [15:0]  XFER_WDATA = 16'h0000, SLAVE_RDATA = 16'h1234, bsd = 16'h0000;
	logic [15:0]  EEPROM_CONTROL_REG = 16'h0000;
	logic [9:0]   IO_BASE = 10'h000;
	logic [19:14] PROM_BASE = 6'h00;
	logic [7:0]   prb = 8'h00;
	logic [3:0]   LED_STATUS = 4'h0, wait_cyc = 4'h0;
	// outputs and resolved shared pins
	logic DACK_N, IOCHRDY, MEMR_N_I, MASTER_N, XFER_DONE, MEMR_N_O, MEMW_N_O, MEMS_OE, SA_OE;
	logic SBHE_N_O, SD_OE, IRQ15_ADDR_PROM_SELECT_N, BOOT_PROM_SELECT_N, PRIVATE_PROM_BUS_OE, SLEEPING;
	logic XCVR_DISABLE_OUT, XCVR_DISABLE_OE, FRAME_REJECT, EXT_ADDR_REJECT_N;
	logic EEPROM_SHIFT_BUSY_O, EEPROM_CHIP_SELECT, EEPROM_CHECKSUM_ERR;
	logic [23:17] LA_O;
	logic [19:0]  SA_I, SA_O;
	logic [15:0]  XFER_RDATA, SD_I, SD_O, SLAVE_WDATA, EEPROM_WORD, host_sd;
	logic [7:0]   PRIVATE_PROM_BUS_I;
	logic [3:0]   LED_N;
	logic [2:0]   PRIVATE_PROM_BUS_O;
	// whoever enables a shared pin sets its level, except private bus bits 7 to 2, which always come from the bench
	assign SA_I = SA_OE ? SA_O : bsa;
	assign MEMR_N_I = MEMS_OE ? MEMR_N_O : bmemr_n;
	assign SD_I = SD_OE ? SD_O : (bsd_en ? bsd : host_sd);
	assign PRIVATE_PROM_BUS_I = PRIVATE_PROM_BUS_OE ? {prb[7:2], PRIVATE_PROM_BUS_O[1:0]} : prb;
	assign EXT_ADDR_REJECT_N = XCVR_DISABLE_OE ? XCVR_DISABLE_OUT : ext_addr_reject_n;
	ibp_top u_ibp_top (.CLOCK, .RST_N, .RESET, .SLEEP_N, .DMA_REQ, .DACK_N, .REF_N, .MASTER_N,
		.XFER_WRITE, .XFER_ADDR, .XFER_HIGH, .XFER_WDATA, .XFER_DONE, .XFER_RDATA, .IOCHRDY,
		.MEMR_N_O, .MEMW_N_O, .MEMS_OE, .MEMR_N_I, .SA_I, .SA_O, .SA_OE, .LA_O, .SBHE_N_O, .AEN,
		.IOR_N, .IOW_N, .SD_I, .SD_O, .SD_OE, .SLAVE_WDATA, .SLAVE_RDATA, .IO_BASE, .PROM_BASE,
		.ADDR_PROM_SELECT_MODE, .IRQ_LEVEL, .IRQ15_ADDR_PROM_SELECT_N, .BOOT_PROM_SELECT_N, .PRIVATE_PROM_BUS_I,
		.PRIVATE_PROM_BUS_O, .PRIVATE_PROM_BUS_OE, .XCVR_DISABLE_POLARITY, .TP_ACTIVE,
		.EXT_ADDR_DETECT_MODE, .EXT_ADDR_REJECT_N, .FILTER_REJECT, .XCVR_DISABLE_OUT,
		.XCVR_DISABLE_OE, .FRAME_REJECT, .LED_STATUS, .START_FRAME_BYTE_DELIM, .SERIAL_RX_DATA,
		.SERIAL_RX_CLOCK, .LED_N, .EEPROM_CONTROL_REG, .EEPROM_RELOAD_BIT, .EEPROM_SHIFT_BUSY_I,
		.EEPROM_SHIFT_BUSY_O, .EEPROM_CHIP_SELECT, .EEPROM_CHECKSUM_ERR, .EEPROM_WORD, .SLEEPING);
	ibp_host_model u_ibp_host_model (.clk(CLOCK), .rst_n(RST_N), .dma_req(DMA_REQ),
		.master_n(MASTER_N), .dack_n(DACK_N), .memr_n(MEMR_N_O), .memw_n(MEMW_N_O),
		.mems_oe(MEMS_OE), .sa(SA_I), .wait_cyc(wait_cyc), .iochrdy(IOCHRDY), .rdata(host_sd));
	initial begin
		CLOCK = 1'b0;
		forever #2 CLOCK = ~CLOCK;
	end
	// drives land on rising edges, checks are taken on falling ones
	task e(input int n);
		repeat (n) @(posedge CLOCK);
	endtask : e
	task n1;
		@(negedge CLOCK);
	endtask : n1
	task stop_test;
		$display("checks %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) $display("Run complete: PASS");
		else $display("Run complete: FAIL");
		$finish;
	endtask : stop_test
	// waits out one serial read and judges busy, select and the checksum flag
	task ee_wait(input logic pull);
		for (i = 0; i < 20 && EEPROM_SHIFT_BUSY_O !== 1'b1; i++) n1();
		`CHK({EEPROM_SHIFT_BUSY_O,EEPROM_CHIP_SELECT},2'b11)
		for (i = 0; i < 2 * EE_BITS * EE_HALF_CYC + 99 && EEPROM_SHIFT_BUSY_O !== 1'b0; i++) n1();
		`CHK({EEPROM_SHIFT_BUSY_O,EEPROM_CHECKSUM_ERR},{1'b0,!pull})
	endtask : ee_wait
	task t_reset;
		n1();
		`CHK({MASTER_N,SA_OE,SD_OE,MEMS_OE,LED_N},{4'b1000,4'hF})
		e(1);
		LED_STATUS <= 4'h3;
		RESET <= 1'b1;
		e(RESET_MIN_CYC);
		n1();
		`CHK({MASTER_N,SA_OE,SD_OE,MEMS_OE,LED_N},{4'b1000,4'hF})
		e(1);
		RESET <= 1'b0;
		ee_wait(1'b1); // the automatic read follows every reset
		$display("t_reset done");
	endtask : t_reset
	task t_ref;
		e(1);
		REF_N <= 1'b0;
		DMA_REQ <= 1'b1;
		for (int k = 0; k < 30; k++) begin
			n1();
			`CHK(MASTER_N,1'b1)
		end
		e(1);
		DMA_REQ <= 1'b0;
		e(6);
		REF_N <= 1'b1;
		e(4);
		$display("t_ref done");
	endtask : t_ref
	task xfer(input logic wr, input logic hi, input logic [23:0] a, input logic [15:0] d,
		input logic [3:0] ws);
		int w;
		e(1);
		{wait_cyc, XFER_WRITE, XFER_HIGH, XFER_ADDR, XFER_WDATA} <= {ws, wr, hi, a, d};
		DMA_REQ <= 1'b1;
		for (i = 0; i < 40 && MASTER_N !== 1'b0; i++) n1();
		`CHK(MASTER_N,1'b0)
		e(1);
		DMA_REQ <= 1'b0;
		for (i = 0; i < 20 && (MEMR_N_O & MEMW_N_O) !== 1'b0; i++) n1();
		`CHK({SA_OE,SA_O},{1'b1,a[19:0]})
		`CHK(LA_O,a[23:17])
		`CHK(SBHE_N_O,!hi)
		`CHK({MEMR_N_O,MEMW_N_O,MEMS_OE},{wr,!wr,1'b1})
		if (wr) `CHK({SD_OE,SD_O},{1'b1,d})
		for (w = 0; w < 60 && XFER_DONE !== 1'b1; w++) n1();
		`CHK({XFER_DONE,w >= int'(ws)},2'b11)
		if (!wr) `CHK(XFER_RDATA,a[15:0] ^ 16'h5A3C)
		e(3);
		n1();
		`CHK({MASTER_N,SA_OE},2'b10)
		$display("xfer done");
	endtask : xfer
	task t_slave;
		e(1);
		{ADDR_PROM_SELECT_MODE, IO_BASE, prb, bsa, AEN, IOR_N} <= {1'b1, 10'h300, 8'hC6, 20'h0030F, 2'b00};
		for (i = 0; i < 10 && SD_OE !== 1'b1; i++) n1();
		`CHK({IRQ15_ADDR_PROM_SELECT_N,SD_O[7:0]},{1'b0,8'hC6})
		e(1);
		IOR_N <= 1'b1;
		bsa <= 20'h00310;
		e(2);
		IOR_N <= 1'b0;
		e(6);
		n1();
		`CHK(IRQ15_ADDR_PROM_SELECT_N,1'b1)
		e(1);
		{IOR_N, bsa, bsd, bsd_en, IOW_N} <= {1'b1, 20'h00302, 16'hBEEF, 2'b10};
		e(6);
		n1();
		`CHK(SLAVE_WDATA,16'hBEEF)
		e(1);
		{IOW_N, bsd_en, IOR_N, ADDR_PROM_SELECT_MODE, IRQ_LEVEL} <= 5'b10000;
		e(4);
		n1();
		`CHK({IRQ15_ADDR_PROM_SELECT_N,SD_OE,SD_O},{2'b11,16'h1234})
		e(1);
		{AEN, IOR_N, IRQ_LEVEL} <= 3'b111;
		e(4);
		n1();
		`CHK(IRQ15_ADDR_PROM_SELECT_N,1'b0)
		$display("t_slave done");
	endtask : t_slave
	task t_boot;
		e(1);
		{PROM_BASE, bsa, prb, bmemr_n, IRQ_LEVEL} <= {6'h33, 6'h33, 14'h0123, 8'h5A, 2'b00};
		e(4);
		n1();
		`CHK({BOOT_PROM_SELECT_N,SD_OE,SD_O[7:0]},{2'b01,8'h5A})
		e(1);
		REF_N <= 1'b0;
		e(4);
		n1();
		`CHK(BOOT_PROM_SELECT_N,1'b1)
		e(1);
		{REF_N, bsa} <= {1'b1, 6'h32, 14'h0123};
		e(4);
		n1();
		`CHK(BOOT_PROM_SELECT_N,1'b1)
		e(1);
		bmemr_n <= 1'b1;
		$display("t_boot done");
	endtask : t_boot
	task t_pins;
		for (int k = 0; k < 4; k++) begin
			e(1);
			{XCVR_DISABLE_POLARITY, TP_ACTIVE, LED_STATUS} <= {k[1:0], k[3:0] ^ 4'h9};
			e(4);
			n1();
			`CHK({XCVR_DISABLE_OE,XCVR_DISABLE_OUT},{1'b1,k[0] ^ k[1]})
			`CHK(LED_N,~(k[3:0] ^ 4'h9))
		end
		for (int k = 0; k < 16; k++) begin
			e(1);
			{EXT_ADDR_DETECT_MODE, FILTER_REJECT, ext_addr_reject_n} <= {1'b1, k[0], k[1]};
			{START_FRAME_BYTE_DELIM, SERIAL_RX_DATA, SERIAL_RX_CLOCK} <= k[3:1];
			e(5);
			n1();
			`CHK({XCVR_DISABLE_OE,FRAME_REJECT},{1'b0,k[0] | !k[1]})
			`CHK(LED_N,~{k[1],k[2],k[3],1'b0})
		end
		e(1);
		EXT_ADDR_DETECT_MODE <= 1'b0;
		$display("t_pins done");
	endtask : t_pins
	task eeprom_reload_bit(input logic pull, input logic [7:0] p);
		e(1);
		{EEPROM_CONTROL_REG, EEPROM_SHIFT_BUSY_I, prb, EEPROM_RELOAD_BIT} <= {16'h0, pull, p, 1'b1};
		ee_wait(pull);
		e(1);
		EEPROM_RELOAD_BIT <= 1'b0;
	endtask : eeprom_reload_bit
	task t_ee;
		for (int k = 0; k < 9; k++) begin
			e(1);
			EEPROM_CONTROL_REG <= {11'h0, k < 8, 1'b0, k[2:0]};
			e(4);
			n1();
			`CHK({PRIVATE_PROM_BUS_OE,EEPROM_CHIP_SELECT},{k < 8,k[2] && k < 8})
			if (k < 8) `CHK(PRIVATE_PROM_BUS_O[1:0],k[1:0])
		end
		eeprom_reload_bit(1'b0, 8'h00);
		eeprom_reload_bit(1'b1, 8'h04);
		`CHK(EEPROM_WORD,16'hFFFF)
		$display("t_ee done");
	endtask : t_ee
	task t_sleep;
		e(1);
		{LED_STATUS, XCVR_DISABLE_POLARITY, TP_ACTIVE, SLEEP_N} <= 7'h00;
		e(6);
		{LED_STATUS, DMA_REQ} <= 5'h1F;
		e(20);
		n1();
		`CHK({SLEEPING,MASTER_N,LED_N},6'h3F)
		`CHK(XCVR_DISABLE_OUT,1'b1)
		e(1);
		{DMA_REQ, SLEEP_N} <= 2'b01; // no network start follows the wake
		e(20);
		n1();
		`CHK({SLEEPING,LED_N},5'h00)
		$display("t_sleep done");
	endtask : t_sleep
	initial begin
		#60us;
		err_count++;
		$display("[ERR] %0t watchdog expired", $time);
		stop_test();
	end
	initial begin
		e(20);
		RST_N <= 1'b1;
		t_reset();
		t_ref();
		xfer(1'b0, 1'b1, 24'hA54321, 16'h0000, 4'd5);
		xfer(1'b1, 1'b0, 24'h1F0F0E, 16'hC35A, 4'd0);
		t_slave();
		t_boot();
		t_pins();
		t_ee();
		t_sleep();
		stop_test();
	end
endmodule : tb
`default_nettype wire
